// ==== hbjs_pkg.sv ====
package hbjs_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] REG_THRESHOLDS = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_SENSE = 8'h14;

  // Status field positions
  localparam int BIT_VOLUME_UP = 7;
  localparam int BIT_VOLUME_DOWN = 6;
  localparam int BIT_BOOST_OV = 5;
  localparam int BIT_LINE_OC = 4;
  localparam int BIT_MIC_SWITCH = 3;
  localparam int BIT_SEND_END = 2;
  localparam int BIT_JACK_N = 1;
  localparam int BIT_DETECT_N = 0;

  // Threshold byte positions in the threshold word
  localparam int POS_THRESHOLD_0 = 0;
  localparam int POS_THRESHOLD_1 = 8;
  localparam int POS_THRESHOLD_2 = 16;
  localparam int POS_THRESHOLD_3 = 24;

  // Config and sense field positions
  localparam int POS_COMM_SEL = 0;
  localparam int POS_SPARE_FLAG = 8;

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [31:0] THRESHOLDS_RESET = 32'h00000000;
  localparam logic [1:0] COMM_SEL_RESET = 2'h0;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // Timing
  localparam int CLK_FREQ_MHZ = 25;
  localparam int DEBOUNCE_TIME_NS = 100000;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

endpackage

// ==== hbjs_pin_filter.sv ====
`timescale 1ns/1ps
module hbjs_pin_filter
#(
  parameter int WIDTH = 1,
  parameter int HOLD_CYCLES = 1
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Raw pins and filtered levels
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  // Refuse shapes the counter cannot serve
  generate
    if (WIDTH < 1 || HOLD_CYCLES < 1)
    begin : g_bad_params
      $error("hbjs_pin_filter: WIDTH and HOLD_CYCLES must be at least 1");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      logic [2:0] sync;
      logic [CW-1:0] count;
      logic level;
      logic agreed;

      // Three-stage synchroniser, first stage feeds only the second
      always_ff @(posedge i_sys_clk or negedge i_rstn)
      begin
        if (!i_rstn)
          sync <= 3'h0;
        else
          sync <= {sync[1:0], i_pin[i]};
      end

      // Change counts once stages two and three agree
      assign agreed = (sync[1] == sync[2]);

      // Hold the new value for HOLD_CYCLES before taking it
      always_ff @(posedge i_sys_clk or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          count <= '0;
          level <= 1'b0;
        end
        else if (!agreed || sync[2] == level)
          count <= '0;
        else if (count == CW'(HOLD_CYCLES - 1))
        begin
          level <= sync[2];
          count <= '0;
        end
        else
          count <= count + CW'(1);
      end

      assign o_level[i] = level;
    end
  endgenerate

endmodule

// ==== hbjs_top.sv ====
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
// Function
// R1: Bypass: volume up flag set when threshold 1 < result < threshold 2.
// R2: Bypass: volume down flag set when threshold 2 < result < threshold 3.
// R3: Bypass: send/end flag set when threshold 0 < result < threshold 1.
// R4: All button flags cleared when bypass open or mic line above level.
// R5: Button flags update only in bypass, from low-gain conversions.
// R6: Bit 5 shows boost overvoltage seen in bypass mode.
// R7: Bit 1 is 0 once jack detected after debounce, 1 otherwise.
// R8: Bit 0 is 0 when detect input sensed, 1 otherwise.
// R9: Bit 4 shows current protection tripped, bit 3 microphone switch closed.
// R10: Status register read-only, writes ignored, reads zero after reset.
// R11: Button counts only after mic line stays below level for debounce time.
// R12: Bypass: spare button flag set when result exceeds threshold 3.
module hbjs_top
#(
  parameter int DEBOUNCE_CYCLES = hbjs_pkg::DEBOUNCE_CYCLES
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // Interrupt
  output logic o_irq,
  // Analog status pins
  input wire logic i_bypass_closed,
  input wire logic i_boost_overvoltage,
  input wire logic i_line_overcurrent,
  input wire logic i_mic_switch_closed,
  input wire logic i_jack_present,
  input wire logic i_detect_pin_sensed,
  input wire logic [3:0] i_mic_below_level,
  // Sense converter, same clock
  input wire logic i_adc_valid,
  input wire logic i_adc_low_gain,
  input wire logic [7:0] i_adc_data
);

  // Refuse a debounce the filter cannot serve
  generate
    if (DEBOUNCE_CYCLES < 1)
    begin : g_bad_debounce
      $error("hbjs_top: DEBOUNCE_CYCLES must be at least 1");
    end
  endgenerate

  // Software-held settings
  logic [7:0] button_threshold_0;
  logic [7:0] button_threshold_1;
  logic [7:0] button_threshold_2;
  logic [7:0] button_threshold_3;
  logic [1:0] comm_threshold_sel;
  logic [7:0] irq_mask;

  // Block state
  logic [7:0] button_jack_status;
  logic [7:0] next_status;
  logic [7:0] irq_status;
  logic [7:0] status_event;
  logic [7:0] sense_adc_result;
  logic volume_up_flag;
  logic volume_down_flag;
  logic send_end_flag;
  logic spare_button_flag;

  // Filtered pins
  logic [4:0] fast_level;
  logic [1:0] slow_level;
  logic bypass_closed;
  logic boost_ov_level;
  logic overcurrent_level;
  logic mic_switch_level;
  logic detect_pin_level;
  logic jack_debounced;
  logic mic_below_debounced;
  logic mic_below_raw;

  // Bus decode
  logic bus_req;
  logic bus_write;
  logic bus_read;
  logic hit_thresholds;
  logic hit_status;
  logic hit_config;
  logic hit_irq_status;
  logic hit_irq_mask;
  logic hit_sense;
  logic irq_read_clear;
  logic [31:0] next_rdata;

  // Classification of the latest sample
  logic in_send_end;
  logic in_volume_up;
  logic in_volume_down;
  logic in_spare;
  logic button_window_open;
  logic take_sample;

  // Comparator for the chosen communication level, muxed ahead of sync
  always_comb
  begin
    mic_below_raw = i_mic_below_level[comm_threshold_sel];
  end

  // Undebounced status pins
  hbjs_pin_filter
  #(
    .WIDTH(5),
    .HOLD_CYCLES(1)
  )
  u_fast_pins
  (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_pin({i_bypass_closed, i_boost_overvoltage, i_line_overcurrent,
            i_mic_switch_closed, i_detect_pin_sensed}),
    .o_level(fast_level)
  );

  // Jack and mic line held for the debounce time
  hbjs_pin_filter
  #(
    .WIDTH(2),
    .HOLD_CYCLES(DEBOUNCE_CYCLES)
  )
  u_slow_pins
  (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_pin({i_jack_present, mic_below_raw}),
    .o_level(slow_level)
  );

  assign bypass_closed = fast_level[4];
  assign boost_ov_level = fast_level[3];
  assign overcurrent_level = fast_level[2];
  assign mic_switch_level = fast_level[1];
  assign detect_pin_level = fast_level[0];
  assign jack_debounced = slow_level[1];
  assign mic_below_debounced = slow_level[0];

  // Strict window compares against the thresholds
  assign in_send_end = (button_threshold_0 < i_adc_data) && (i_adc_data < button_threshold_1); // [R3]
  assign in_volume_up = (button_threshold_1 < i_adc_data) && (i_adc_data < button_threshold_2); // [R1]
  assign in_volume_down = (button_threshold_2 < i_adc_data) && (i_adc_data < button_threshold_3); // [R2]
  assign in_spare = (button_threshold_3 < i_adc_data); // [R12]

  // Flags live only while bypassed and the mic line has dropped
  assign button_window_open = bypass_closed && mic_below_debounced; // [R4] [R11]
  assign take_sample = i_adc_valid && i_adc_low_gain; // [R5]

  // Button classification flags
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      volume_up_flag <= 1'b0;
      volume_down_flag <= 1'b0;
      send_end_flag <= 1'b0;
      spare_button_flag <= 1'b0;
    end
    else if (!button_window_open)
    begin
      volume_up_flag <= 1'b0; // [R4]
      volume_down_flag <= 1'b0; // [R4]
      send_end_flag <= 1'b0; // [R4]
      spare_button_flag <= 1'b0;
    end
    else if (take_sample) // [R5]
    begin
      volume_up_flag <= in_volume_up; // [R1]
      volume_down_flag <= in_volume_down; // [R2]
      send_end_flag <= in_send_end; // [R3]
      spare_button_flag <= in_spare; // [R12]
    end
  end

  // Latest converter result, any gain
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      sense_adc_result <= 8'h00;
    else if (i_adc_valid)
      sense_adc_result <= i_adc_data;
  end

  // Assemble the status byte from block state
  always_comb
  begin
    next_status = hbjs_pkg::STATUS_RESET;
    next_status[hbjs_pkg::BIT_VOLUME_UP] = volume_up_flag; // [R1]
    next_status[hbjs_pkg::BIT_VOLUME_DOWN] = volume_down_flag; // [R2]
    next_status[hbjs_pkg::BIT_BOOST_OV] = boost_ov_level && bypass_closed; // [R6]
    next_status[hbjs_pkg::BIT_LINE_OC] = overcurrent_level; // [R9]
    next_status[hbjs_pkg::BIT_MIC_SWITCH] = mic_switch_level; // [R9]
    next_status[hbjs_pkg::BIT_SEND_END] = send_end_flag; // [R3]
    next_status[hbjs_pkg::BIT_JACK_N] = !jack_debounced; // [R7]
    next_status[hbjs_pkg::BIT_DETECT_N] = !detect_pin_level; // [R8]
  end

  // Status register, driven only by hardware
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      button_jack_status <= hbjs_pkg::STATUS_RESET; // [R10]
    else
      button_jack_status <= next_status;
  end

  // Wishbone request qualification, one answer per request
  assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign bus_write = bus_req && i_wb_we;
  assign bus_read = bus_req && !i_wb_we;
  assign hit_thresholds = (i_wb_adr == hbjs_pkg::REG_THRESHOLDS);
  assign hit_status = (i_wb_adr == hbjs_pkg::REG_STATUS);
  assign hit_config = (i_wb_adr == hbjs_pkg::REG_CONFIG);
  assign hit_irq_status = (i_wb_adr == hbjs_pkg::REG_IRQ_STATUS);
  assign hit_irq_mask = (i_wb_adr == hbjs_pkg::REG_IRQ_MASK);
  assign hit_sense = (i_wb_adr == hbjs_pkg::REG_SENSE);
  assign irq_read_clear = bus_read && hit_irq_status;

  // Threshold bytes, one byte lane each
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      button_threshold_0 <= hbjs_pkg::THRESHOLDS_RESET[hbjs_pkg::POS_THRESHOLD_0 +: 8];
      button_threshold_1 <= hbjs_pkg::THRESHOLDS_RESET[hbjs_pkg::POS_THRESHOLD_1 +: 8];
      button_threshold_2 <= hbjs_pkg::THRESHOLDS_RESET[hbjs_pkg::POS_THRESHOLD_2 +: 8];
      button_threshold_3 <= hbjs_pkg::THRESHOLDS_RESET[hbjs_pkg::POS_THRESHOLD_3 +: 8];
    end
    else if (bus_write && hit_thresholds)
    begin
      if (i_wb_sel[0])
        button_threshold_0 <= i_wb_dat[hbjs_pkg::POS_THRESHOLD_0 +: 8];
      if (i_wb_sel[1])
        button_threshold_1 <= i_wb_dat[hbjs_pkg::POS_THRESHOLD_1 +: 8];
      if (i_wb_sel[2])
        button_threshold_2 <= i_wb_dat[hbjs_pkg::POS_THRESHOLD_2 +: 8];
      if (i_wb_sel[3])
        button_threshold_3 <= i_wb_dat[hbjs_pkg::POS_THRESHOLD_3 +: 8];
    end
  end

  // Communication level select
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      comm_threshold_sel <= hbjs_pkg::COMM_SEL_RESET;
    else if (bus_write && hit_config && i_wb_sel[0])
      comm_threshold_sel <= i_wb_dat[hbjs_pkg::POS_COMM_SEL +: 2]; // [R11]
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_mask <= hbjs_pkg::IRQ_MASK_RESET;
    else if (bus_write && hit_irq_mask && i_wb_sel[0])
      irq_mask <= i_wb_dat[7:0];
  end

  // Any change of a status bit is an event
  assign status_event = next_status ^ button_jack_status;

  // Sticky event bits, cleared by a read, a new event wins
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_status <= 8'h00;
    else if (irq_read_clear)
      irq_status <= status_event;
    else
      irq_status <= irq_status | status_event;
  end

  // Level interrupt while any unmasked event is pending
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_status & irq_mask);
  end

  // Read mux; status writes fall through untouched
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (hit_thresholds)
    begin
      next_rdata[hbjs_pkg::POS_THRESHOLD_0 +: 8] = button_threshold_0;
      next_rdata[hbjs_pkg::POS_THRESHOLD_1 +: 8] = button_threshold_1;
      next_rdata[hbjs_pkg::POS_THRESHOLD_2 +: 8] = button_threshold_2;
      next_rdata[hbjs_pkg::POS_THRESHOLD_3 +: 8] = button_threshold_3;
    end
    else if (hit_status)
      next_rdata[7:0] = button_jack_status; // [R10]
    else if (hit_config)
      next_rdata[hbjs_pkg::POS_COMM_SEL +: 2] = comm_threshold_sel;
    else if (hit_irq_status)
      next_rdata[7:0] = irq_status;
    else if (hit_irq_mask)
      next_rdata[7:0] = irq_mask;
    else if (hit_sense)
    begin
      next_rdata[7:0] = sense_adc_result;
      next_rdata[hbjs_pkg::POS_SPARE_FLAG] = spare_button_flag; // [R12]
    end
  end

  // Acknowledge one cycle after the request, drop the cycle after
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_wb_ack <= 1'b0;
    else
      o_wb_ack <= bus_req;
  end

  // Read data registered with the acknowledge
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_wb_dat <= 32'h00000000;
    else if (bus_read)
      o_wb_dat <= next_rdata;
    else if (bus_req)
      o_wb_dat <= 32'h00000000;
  end

endmodule

// ==== hbjs_chk.sv ====
`timescale 1ns/1ps
module hbjs_chk
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Bus
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  // Pins
  input wire logic i_bypass_closed,
  input wire logic i_boost_overvoltage,
  input wire logic i_line_overcurrent,
  input wire logic i_mic_switch_closed,
  input wire logic i_detect_pin_sensed
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic rd;
  // Status word answered on the bus
  assign rd = o_wb_ack && !i_wb_we && i_wb_adr == 8'h04;
  a_upper_zero: assert property (rd |-> o_wb_dat[31:8] == 24'h000000)
    else $error("status upper bits set");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_oc_bit: assert property (rd && $past(i_line_overcurrent, 8) == i_line_overcurrent
    |-> o_wb_dat[4] == i_line_overcurrent) else $error("overcurrent bit wrong");
  a_mic_bit: assert property (rd && $past(i_mic_switch_closed, 8) == i_mic_switch_closed
    |-> o_wb_dat[3] == i_mic_switch_closed) else $error("mic switch bit wrong");
  a_detect_bit: assert property (rd && $past(i_detect_pin_sensed, 8) == i_detect_pin_sensed
    |-> o_wb_dat[0] == !i_detect_pin_sensed) else $error("detect bit wrong");
  a_boost_bit: assert property (rd && $past(i_boost_overvoltage, 8) == i_boost_overvoltage
    && $past(i_bypass_closed, 8) == i_bypass_closed
    |-> o_wb_dat[5] == (i_boost_overvoltage && i_bypass_closed)) else $error("boost bit wrong");
  a_flags_open: assert property (rd && !i_bypass_closed && !$past(i_bypass_closed, 8)
    |-> {o_wb_dat[7:6], o_wb_dat[2]} == 3'h0) else $error("button flag while bypass open");
  a_flags_onehot: assert property (rd |-> $onehot0({o_wb_dat[7:6], o_wb_dat[2]}))
    else $error("two button flags at once");
endmodule
bind hbjs_top hbjs_chk u_chk (.i_sys_clk, .i_rstn, .i_wb_we, .i_wb_adr, .o_wb_ack, .o_wb_dat,
  .i_bypass_closed, .i_boost_overvoltage, .i_line_overcurrent, .i_mic_switch_closed, .i_detect_pin_sensed);

// ==== hbjs_headset_model.sv ====
`timescale 1ns/1ps
module hbjs_headset_model
(
  // Clock
  input wire logic i_sys_clk,
  // Pins: bypass, boost, overcurrent, mic switch, jack, detect
  output logic [5:0] o_pins,
  output logic [3:0] o_mic_below,
  // Sense converter
  output logic o_adc_valid,
  output logic o_adc_low_gain,
  output logic [7:0] o_adc_data
);
  // Idle accessory
  initial
  begin
    o_pins = 6'h00;
    o_mic_below = 4'h0;
    o_adc_valid = 1'b0;
    o_adc_low_gain = 1'b0;
    o_adc_data = 8'h00;
  end
  // New pin levels after an edge
  task set_pins(input logic [5:0] p, input logic [3:0] m);
    @(posedge i_sys_clk);
    o_pins <= p;
    o_mic_below <= m;
  endtask
  // One conversion; lines show the inverse once released
  task sample(input logic [7:0] v, input logic lg);
    @(posedge i_sys_clk);
    o_adc_valid <= 1'b1;
    o_adc_low_gain <= lg;
    o_adc_data <= v;
    @(posedge i_sys_clk);
    o_adc_valid <= 1'b0;
    o_adc_low_gain <= !lg;
    o_adc_data <= ~v;
  endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic clk, rstn, cyc, stb, we, ack, irq, av, alg;
  logic [7:0] adr, ad;
  logic [31:0] wdat, rdat, d;
  logic [3:0] sel, mb;
  logic [5:0] p;
  int n_mismatch = 0;
  int compares = 0;
  hbjs_top #(.DEBOUNCE_CYCLES(4)) DUT (.i_sys_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_ack(ack), .o_wb_dat(rdat),
    .o_irq(irq), .i_bypass_closed(p[5]), .i_boost_overvoltage(p[4]), .i_line_overcurrent(p[3]),
    .i_mic_switch_closed(p[2]), .i_jack_present(p[1]), .i_detect_pin_sensed(p[0]),
    .i_mic_below_level(mb), .i_adc_valid(av), .i_adc_low_gain(alg), .i_adc_data(ad));
  hbjs_headset_model P (.i_sys_clk(clk), .o_pins(p), .o_mic_below(mb), .o_adc_valid(av),
    .o_adc_low_gain(alg), .o_adc_data(ad));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Value comparison
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %0h", $time, m, got);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One classic bus cycle, result in d
  task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    sel <= 4'hF;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k == 50)
    begin
      n_mismatch++;
      $display("unexpected at %0t: no ack", $time);
      tally_and_finish;
    end
  endtask
  // Outputs quiet in reset
  task t_reset;
    chk(rdat, 32'h00000000, "read data in reset");
    chk({30'h0, ack, irq}, 32'h00000000, "ack or irq in reset");
    $display("test reset done");
  endtask
  // Pin bits, write ignored, unmapped read
  task t_pins;
    logic [5:0] pv[2] = '{6'h1E, 6'h31};
    logic [31:0] ev[2] = '{32'h19, 32'h22};
    for (int i = 0; i < 2; i++)
    begin
      P.set_pins(pv[i], 4'h0);
      repeat (20) @(posedge clk);
      wb(1'b0, 8'h04, 32'h0);
      chk(d, ev[i], "status pins");
    end
    wb(1'b1, 8'h04, 32'hFFFFFFFF);
    wb(1'b0, 8'h04, 32'h0);
    chk(d, 32'h22, "status after write");
    wb(1'b0, 8'h40, 32'h0);
    chk(d, 32'h00000000, "unmapped read");
    $display("test pins done");
  endtask
  // Button classes, boundaries, gain and level gating
  task t_buttons;
    logic [7:0] v[8] = '{8'h30, 8'h60, 8'h30, 8'hA0, 8'h40, 8'hD0, 8'h1F, 8'h60};
    logic g[8] = '{1, 1, 0, 1, 1, 1, 1, 1};
    logic [7:0] f[8] = '{8'h04, 8'h80, 8'h80, 8'h40, 8'h00, 8'h00, 8'h00, 8'h80};
    wb(1'b1, 8'h00, 32'hC0804020);
    wb(1'b1, 8'h08, 32'h00000001);
    wb(1'b0, 8'h00, 32'h0);
    chk(d, 32'hC0804020, "threshold readback");
    wb(1'b0, 8'h08, 32'h0);
    chk(d, 32'h00000001, "level select readback");
    P.set_pins(6'h21, 4'h2);
    repeat (20) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      P.sample(v[i], g[i]);
      repeat (4) @(posedge clk);
      wb(1'b0, 8'h04, 32'h0);
      chk(d, {24'h0, f[i] | 8'h02}, "button flags");
      wb(1'b0, 8'h14, 32'h0);
      chk({31'h0, d[8]}, {31'h0, v[i] == 8'hD0}, "spare flag");
      chk({24'h0, d[7:0]}, {24'h0, v[i]}, "sense result");
    end
    P.set_pins(6'h21, 4'hD);
    repeat (20) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0);
    chk(d, 32'h02, "flags with mic above level");
    P.set_pins(6'h21, 4'h2);
    repeat (20) @(posedge clk);
    P.sample(8'h60, 1'b1);
    repeat (4) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0);
    chk(d, 32'h82, "flag before bypass opens");
    P.set_pins(6'h01, 4'h2);
    repeat (20) @(posedge clk);
    wb(1'b0, 8'h04, 32'h0);
    chk(d, 32'h02, "flags with bypass open");
    $display("test buttons done");
  endtask
  // Masked event, unmask, clear on read
  task t_irq;
    wb(1'b0, 8'h0C, 32'h0);
    P.set_pins(6'h05, 4'h2);
    repeat (12) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq while masked");
    wb(1'b1, 8'h10, 32'h00000008);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq after unmask");
    wb(1'b0, 8'h10, 32'h0);
    chk(d, 32'h00000008, "mask readback");
    wb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, d[3]}, 32'h1, "mic switch event");
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    $display("test irq done");
  endtask
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'h0;
    repeat (16) @(posedge clk);
    t_reset;
    rstn <= 1'b1;
    t_pins;
    t_buttons;
    t_irq;
    tally_and_finish;
  end
endmodule
